// >>> rtl/cdgr_cfg.svh
// Purpose: offsets, field positions and reset values of the control bank
// Assumes: included by every module of the bank; the package does not include it
// Notes: register indices are word indices; byte address is four times
`ifndef CDGR_CFG_SVH
`define CDGR_CFG_SVH
// word indices of the registers
`define CDGR_IDX_TRIM 8'h78
`define CDGR_IDX_GAIN 8'h7a
`define CDGR_IDX_MODE 8'h7c
`define CDGR_IDX_PIN0 8'h7d
`define CDGR_IDX_PIN1 8'h7e
// reset values
`define CDGR_RST_GAIN 16'h0000
`define CDGR_RST_TRIM 16'ha0a0
`define CDGR_RST_MODE 16'h0000
// field positions
`define CDGR_AD1_LSB 0
`define CDGR_AD2_LSB 8
`define CDGR_VR1_LSB 0
`define CDGR_VR2_LSB 8
`define CDGR_OPM_LSB 0
`define CDGR_LLA_LSB 2
`define CDGR_LLB_LSB 5
`define CDGR_PIN_DIR 1
`define CDGR_PIN_VAL 0
// lowest gain in dB, at code zero
`define CDGR_GAIN_BASE_DB 5'h09
// highest legal connection code
`define CDGR_CONN_MAX 3'h4
`endif

// >>> rtl/cdgr_pkg.sv
// Purpose: types shared by the control bank
// Assumes: nothing beyond the cfg header
// Notes: mode codes mirror the stored field encodings
package cdgr_pkg;
  // connection mode of one line channel
  typedef enum logic [2:0] {
    CONN_IDLE_RST = 3'h0,
    CONN_IDLE_KEEP = 3'h1,
    CONN_SPEECH_TONE = 3'h2,
    CONN_TONE_GEN = 3'h3,
    CONN_DIAL_DETECT = 3'h4,
    CONN_BAD5 = 3'h5,
    CONN_BAD6 = 3'h6,
    CONN_BAD7 = 3'h7
  } cdgr_conn_t;
  // operation mode of the dsp
  typedef enum logic [1:0] {
    OPM_CONNECT = 2'h0,
    OPM_RAM_RW = 2'h1,
    OPM_SOFT_RESET = 2'h2,
    OPM_BAD = 2'h3
  } cdgr_opm_t;
  // bus slave phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_WRITE = 2'h1,
    BUS_READ = 2'h2,
    BUS_RDATA = 2'h3
  } cdgr_bus_t;
endpackage

// >>> rtl/cdgr_pin.sv
// Purpose: one general-purpose pin with its two-bit control word
// Assumes: pin input is synchronous to hclk
// Notes: bit 1 is direction (1 = input), bit 0 is pin state
`timescale 1ns/100ps
`default_nettype none
`include "cdgr_cfg.svh"
module cdgr_pin (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write side
  input wire logic wr_en,
  input wire logic [1:0] wr_bits,
  // pad
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  // read side
  output logic [1:0] rd_bits
);
  logic dir_q; // 1 = input
  logic val_q; // driven level
  logic in_q; // sampled pad level

  // direction is input during and after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= 1'b1;
    end else if (wr_en) begin
      dir_q <= wr_bits[`CDGR_PIN_DIR];
    end
  end

  // output level, only seen on the pad when dir is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      val_q <= 1'b0;
    end else if (wr_en) begin
      val_q <= wr_bits[`CDGR_PIN_VAL];
    end
  end

  // pad sample, one flop so reads see a clean level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_q <= 1'b0;
    end else begin
      in_q <= pin_i;
    end
  end

  assign pin_o = val_q;
  assign pin_oe = ~dir_q;
  // input pins read back the pad, outputs their driven value
  assign rd_bits = {dir_q, dir_q ? in_q : val_q};
endmodule
`default_nettype wire

// >>> rtl/cdgr_regs.sv
// Purpose: codec gain, reference trim, dsp mode and pin control bank
// Assumes: ahb-lite slave, single word transfers; dsp write port in parallel
// Notes: reads take one wait state, writes none; dsp wins a same-cycle clash
//
// Notes on behaviour
// - adc gain is code plus nine dB
// - gain codes at bits 11:8, 3:0; reset zero
// - trim register sixteen bits, resets to a0a0
// - trim bits 13:8 drive codec two vref
// - trim bits 5:0 drive codec one vref
// - mode register sixteen bits, resets to zero
// - mode bits 15:8 have no function
// - channel b code 7:5, channel a 4:2
// - connection codes 0..4 legal, 5..7 forbidden
// - operation mode 0..2 legal, 3 forbidden
// - pin0 bit1 direction, one means input
// - pin1 same layout as pin0
// - both pins inputs during and after reset
// - dsp may overwrite pin controls after reset
`timescale 1ns/100ps
`default_nettype none
`include "cdgr_cfg.svh"
module cdgr_regs (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // dsp register port
  input wire logic dsp_we,
  input wire logic [7:0] dsp_idx,
  input wire logic [15:0] dsp_wdata,
  output logic [15:0] dsp_rdata,
  // analog codec controls
  output logic [3:0] adc1_gain_code,
  output logic [3:0] adc2_gain_code,
  output logic [4:0] adc1_gain_db,
  output logic [4:0] adc2_gain_db,
  output logic [5:0] first_codec_vref_select,
  output logic [5:0] second_codec_vref_select,
  // dsp mode controls
  output cdgr_pkg::cdgr_conn_t first_line_channel_conn_mode,
  output cdgr_pkg::cdgr_conn_t second_line_channel_conn_mode,
  output cdgr_pkg::cdgr_opm_t operation_mode_select,
  // general-purpose pins
  input wire logic first_general_pin_i,
  output logic first_general_pin_o,
  output logic first_general_pin_oe,
  input wire logic second_general_pin_i,
  output logic second_general_pin_o,
  output logic second_general_pin_oe
);
  import cdgr_pkg::*;

  cdgr_bus_t bus_q, bus_d; // slave phase
  logic [7:0] bus_idx_q; // index captured in the address phase
  logic [31:0] hrdata_q; // registered read data
  logic [15:0] gain_register_q; // codec gains
  logic [15:0] codec_reference_trim_q; // vref trims
  logic [15:0] dsp_channel_mode_q; // dsp modes
  logic [1:0] pin0_rd, pin1_rd; // pin control read-back
  logic wr_en; // merged write strobe
  logic [7:0] wr_idx; // merged write index
  logic [15:0] wr_data; // merged write data
  logic addr_ok; // address phase taken

  // gain in dB for a four-bit code
  function automatic logic [4:0] gain_db(input logic [3:0] code);
    gain_db = {1'b0, code} + `CDGR_GAIN_BASE_DB;
  endfunction

  // forbidden codes leave the old field in place; upper bits forced zero
  function automatic logic [15:0] mode_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v);
    logic [15:0] r;
    r = 16'h0000;
    r[`CDGR_LLA_LSB +: 3] = (new_v[`CDGR_LLA_LSB +: 3] > `CDGR_CONN_MAX) ?
      old_v[`CDGR_LLA_LSB +: 3] : new_v[`CDGR_LLA_LSB +: 3];
    r[`CDGR_LLB_LSB +: 3] = (new_v[`CDGR_LLB_LSB +: 3] > `CDGR_CONN_MAX) ?
      old_v[`CDGR_LLB_LSB +: 3] : new_v[`CDGR_LLB_LSB +: 3];
    r[`CDGR_OPM_LSB +: 2] = (new_v[`CDGR_OPM_LSB +: 2] == OPM_BAD) ?
      old_v[`CDGR_OPM_LSB +: 2] : new_v[`CDGR_OPM_LSB +: 2];
    mode_merge = r;
  endfunction

  // read mux shared by the bus and the dsp; unmapped reads as zero
  function automatic logic [15:0] read_mux(input logic [7:0] idx,
                                           input logic [15:0] g,
                                           input logic [15:0] t,
                                           input logic [15:0] m,
                                           input logic [1:0] p0,
                                           input logic [1:0] p1);
    unique case (idx)
      `CDGR_IDX_GAIN: read_mux = g;
      `CDGR_IDX_TRIM: read_mux = t;
      `CDGR_IDX_MODE: read_mux = m;
      `CDGR_IDX_PIN0: read_mux = {14'h0000, p0};
      `CDGR_IDX_PIN1: read_mux = {14'h0000, p1};
      default: read_mux = 16'h0000;
    endcase
  endfunction

  // address phase: selected, ready and a non-sequential or sequential trans
  assign addr_ok = hsel && hready && htrans[1];

  // slave phase machine; only the first read data cycle stalls
  always_comb begin
    bus_d = BUS_IDLE;
    unique case (bus_q)
      BUS_READ: bus_d = BUS_RDATA;
      BUS_IDLE, BUS_WRITE, BUS_RDATA: begin
        if (addr_ok) begin
          bus_d = hwrite ? BUS_WRITE : BUS_READ;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // index capture; haddr[1:0] ignored since only words are served
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_idx_q <= 8'h00;
    end else if (addr_ok) begin
      bus_idx_q <= haddr[9:2];
    end
  end

  // the wait state lets a write just before a read land first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (bus_q == BUS_READ) begin
      hrdata_q <= {16'h0000, read_mux(bus_idx_q, gain_register_q,
        codec_reference_trim_q, dsp_channel_mode_q, pin0_rd, pin1_rd)};
    end
  end

  // dsp read data, one cycle behind its index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsp_rdata <= 16'h0000;
    end else begin
      dsp_rdata <= read_mux(dsp_idx, gain_register_q,
        codec_reference_trim_q, dsp_channel_mode_q, pin0_rd, pin1_rd);
    end
  end

  // merged write; dsp takes the cycle so its program stays in control
  always_comb begin
    wr_en = 1'b0;
    wr_idx = bus_idx_q;
    wr_data = hwdata[15:0];
    if (dsp_we) begin
      wr_en = 1'b1;
      wr_idx = dsp_idx;
      wr_data = dsp_wdata;
    end else if (bus_q == BUS_WRITE) begin
      wr_en = 1'b1;
    end
  end

  // gain register, zero gives the lowest gain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_register_q <= `CDGR_RST_GAIN;
    end else if (wr_en && wr_idx == `CDGR_IDX_GAIN) begin
      gain_register_q <= wr_data;
    end
  end

  // trim stored as written; the fixed 10 bits are the writer's duty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      codec_reference_trim_q <= `CDGR_RST_TRIM;
    end else if (wr_en && wr_idx == `CDGR_IDX_TRIM) begin
      codec_reference_trim_q <= wr_data;
    end
  end

  // dsp mode register, filtered against forbidden codes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsp_channel_mode_q <= `CDGR_RST_MODE;
    end else if (wr_en && wr_idx == `CDGR_IDX_MODE) begin
      dsp_channel_mode_q <= mode_merge(dsp_channel_mode_q, wr_data);
    end
  end

  // first general pin
  cdgr_pin u_pin0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_en && wr_idx == `CDGR_IDX_PIN0),
    .wr_bits(wr_data[1:0]),
    .pin_i(first_general_pin_i),
    .pin_o(first_general_pin_o),
    .pin_oe(first_general_pin_oe),
    .rd_bits(pin0_rd)
  );

  // second general pin, same layout
  cdgr_pin u_pin1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_en && wr_idx == `CDGR_IDX_PIN1),
    .wr_bits(wr_data[1:0]),
    .pin_i(second_general_pin_i),
    .pin_o(second_general_pin_o),
    .pin_oe(second_general_pin_oe),
    .rd_bits(pin1_rd)
  );

  // bus answers
  assign hreadyout = (bus_q != BUS_READ);
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;

  // field outputs
  assign adc1_gain_code = gain_register_q[`CDGR_AD1_LSB +: 4];
  assign adc2_gain_code = gain_register_q[`CDGR_AD2_LSB +: 4];
  assign adc1_gain_db = gain_db(adc1_gain_code);
  assign adc2_gain_db = gain_db(adc2_gain_code);
  assign first_codec_vref_select =
    codec_reference_trim_q[`CDGR_VR1_LSB +: 6];
  assign second_codec_vref_select =
    codec_reference_trim_q[`CDGR_VR2_LSB +: 6];
  assign first_line_channel_conn_mode =
    cdgr_conn_t'(dsp_channel_mode_q[`CDGR_LLA_LSB +: 3]);
  assign second_line_channel_conn_mode =
    cdgr_conn_t'(dsp_channel_mode_q[`CDGR_LLB_LSB +: 3]);
  assign operation_mode_select =
    cdgr_opm_t'(dsp_channel_mode_q[`CDGR_OPM_LSB +: 2]);

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic first_q; // high in the first cycle after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  property p_gain_db;
    adc2_gain_db == {1'b0, adc2_gain_code} + 5'h09;
  endproperty
  a_gain_db: assert property (p_gain_db) else $error("gain dB wrong");

  property p_gain_wr;
    (wr_en && !dsp_we && wr_idx == `CDGR_IDX_GAIN) |=>
      adc1_gain_code == $past(hwdata[3:0]) &&
      adc2_gain_code == $past(hwdata[11:8]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");

  property p_reset_vals;
    first_q |-> codec_reference_trim_q == 16'ha0a0 &&
      gain_register_q == 16'h0000 && dsp_channel_mode_q == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset");

  property p_vref;
    (dsp_we && dsp_idx == `CDGR_IDX_TRIM) |=>
      second_codec_vref_select == $past(dsp_wdata[13:8]) &&
      first_codec_vref_select == $past(dsp_wdata[5:0]);
  endproperty
  a_vref: assert property (p_vref) else $error("vref fields wrong");

  property p_mode_upper;
    bus_q == BUS_RDATA && bus_idx_q == `CDGR_IDX_MODE |->
      hrdata[31:8] == 24'h000000;
  endproperty
  a_mode_upper: assert property (p_mode_upper) else $error("mode hi bits");

  property p_conn_bad;
    (dsp_we && dsp_idx == `CDGR_IDX_MODE && dsp_wdata[4:2] > 3'h4) |=>
      first_line_channel_conn_mode == $past(first_line_channel_conn_mode);
  endproperty
  a_conn_bad: assert property (p_conn_bad) else $error("bad conn stored");

  property p_opm_bad;
    (dsp_we && dsp_idx == `CDGR_IDX_MODE && dsp_wdata[1:0] == 2'h3) |=>
      operation_mode_select == $past(operation_mode_select);
  endproperty
  a_opm_bad: assert property (p_opm_bad) else $error("bad opm stored");

  property p_pin_dir;
    (wr_en && wr_idx == `CDGR_IDX_PIN0) |=>
      first_general_pin_oe == !$past(wr_data[1]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin0 dir wrong");

  property p_pin_reset;
    first_q |-> !first_general_pin_oe && !second_general_pin_oe;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin not input");

  property p_read_wait;
    (bus_q != BUS_READ && addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read timing");

  c_bus_write: cover property (bus_q == BUS_WRITE);
  c_bus_read: cover property (bus_q == BUS_RDATA);
  c_dsp_pin: cover property (dsp_we && dsp_idx == `CDGR_IDX_PIN1);
  c_pin_out: cover property (first_general_pin_oe);
endmodule
`default_nettype wire

// >>> sim/cdgr_dsp_model.sv
// Purpose: stand-in for the on-chip dsp and the two pads
// Assumes: writes are issued at a rising hclk edge, by non-blocking update
// Notes: the pad drives its own level only while the bank is not driving
`timescale 1ns/100ps
`default_nettype none
module cdgr_dsp_model (
  // clock
  input wire logic hclk,
  // dsp write port
  output logic dsp_we,
  output logic [7:0] dsp_idx,
  output logic [15:0] dsp_wdata,
  // pads
  input wire logic [1:0] pad_o,
  input wire logic [1:0] pad_oe,
  input wire logic [1:0] pad_ext,
  output logic [1:0] pad_i
);
  // wire level: the bank wins while its enable is high
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & pad_ext);
  // port idle at time zero
  initial begin
    dsp_we <= 1'b0;
    dsp_idx <= 8'h00;
    dsp_wdata <= 16'h0000;
  end
  // one-cycle write pulse; callers keep trim 10 bits and legal codes
  // called at a rising edge, returns one quiet edge later so that two
  // calls in a row never touch the strobe twice in one time step
  task automatic put(input logic [7:0] i, input logic [15:0] d);
    dsp_we <= 1'b1;
    dsp_idx <= i;
    dsp_wdata <= d;
    @(posedge hclk);
    dsp_we <= 1'b0;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// >>> sim/codec_dsp_gpio_control_regs_bench.sv
// Purpose: self-checking bench for the codec control bank
// Assumes: ahb-lite single word transfers, hready tied to hreadyout
// Notes: tasks start and end at a rising edge; outputs are looked at on
// the falling edge, where they have settled
`timescale 1ns/100ps
`default_nettype none
module codec_dsp_gpio_control_regs_bench;
  // bus side; hready is the slave's own hreadyout
  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // dsp port, driven by the partner model
  logic dsp_we;
  logic [7:0] dsp_idx;
  logic [15:0] dsp_wdata, dsp_rdata;
  // codec and mode controls
  logic [3:0] g1, g2;
  logic [4:0] db1, db2;
  logic [5:0] vr1, vr2;
  cdgr_pkg::cdgr_conn_t ca, cb;
  cdgr_pkg::cdgr_opm_t opm;
  // pads: bank side and the level from outside
  logic po0, po1, pe0, pe1;
  logic [1:0] pad_ext, pad_i;
  int n_fail, compares;

  cdgr_regs DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .dsp_we(dsp_we), .dsp_idx(dsp_idx), .dsp_wdata(dsp_wdata),
    .dsp_rdata(dsp_rdata), .adc1_gain_code(g1), .adc2_gain_code(g2),
    .adc1_gain_db(db1), .adc2_gain_db(db2),
    .first_codec_vref_select(vr1), .second_codec_vref_select(vr2),
    .first_line_channel_conn_mode(ca),
    .second_line_channel_conn_mode(cb), .operation_mode_select(opm),
    .first_general_pin_i(pad_i[0]), .first_general_pin_o(po0),
    .first_general_pin_oe(pe0), .second_general_pin_i(pad_i[1]),
    .second_general_pin_o(po1), .second_general_pin_oe(pe1)
  );

  cdgr_dsp_model u_dsp (
    .hclk(hclk), .dsp_we(dsp_we), .dsp_idx(dsp_idx), .dsp_wdata(dsp_wdata),
    .pad_o({po1, po0}), .pad_oe({pe1, pe0}), .pad_ext(pad_ext),
    .pad_i(pad_i)
  );

  // 10 MHz bus clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // compare one value; an unknown counts as a mismatch
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run, reached from the tests and the watchdog
  task automatic complete_run;
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one single transfer; called at a rising edge, returns at one
  // hready only moves at rising edges, so its mid-cycle level is the one
  // that the next edge samples
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd_v);
    logic ok;
    ok = 1'b0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h000000, idx, 2'h0};
    // address phase stands until hready is high at an edge
    while (!ok) begin
      @(negedge hclk);
      ok = hready;
      @(posedge hclk);
    end
    htrans <= 2'h0;
    hwdata <= wd;
    ok = 1'b0;
    // data phase; read data taken at the edge where hready is high
    while (!ok) begin
      @(negedge hclk);
      ok = hready;
      rd_v = hrdata;
      @(posedge hclk);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, idx, d, dummy);
  endtask

  task automatic rd(input string name, input logic [7:0] idx,
                    input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, idx, 32'h0000_0000, v);
    chk(name, v, exp);
    chk("hresp", hresp, 32'h0000_0000);
  endtask

  // reset driven at a rising edge, released at one
  task automatic do_reset(input int cycles);
    hresetn <= 1'b0;
    repeat (cycles) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // outputs in the first cycle after release; returns at the next edge
  task automatic reset_look;
    @(negedge hclk);
    chk("adc1_db", db1, 32'h0000_0009);
    chk("adc2_code", g2, 32'h0000_0000);
    chk("vref1", vr1, 32'h0000_0020);
    chk("vref2", vr2, 32'h0000_0020);
    chk("conn_b", cb, 32'h0000_0000);
    chk("opm", opm, 32'h0000_0000);
    chk("pin0_oe", pe0, 32'h0000_0000);
    chk("pin1_oe", pe1, 32'h0000_0000);
    @(posedge hclk);
  endtask

  // tests; about 85 cycles in all
  initial begin
    n_fail = 0;
    compares = 0;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    haddr <= 32'h0000_0000;
    hwdata <= 32'h0000_0000;
    pad_ext <= 2'b10;
    do_reset(16);
    reset_look();
    rd("gain_rst", 8'h7a, 32'h0000_0000);
    rd("trim_rst", 8'h78, 32'h0000_a0a0);
    rd("mode_rst", 8'h7c, 32'h0000_0000);
    rd("pin0_rst", 8'h7d, 32'h0000_0002);
    rd("pin1_pad", 8'h7e, 32'h0000_0003);
    // gains: all sixteen bits kept, codes map to code plus nine dB
    wr(8'h7a, 32'h0000_ab0f);
    rd("gain", 8'h7a, 32'h0000_ab0f);
    @(negedge hclk);
    chk("adc1_code", g1, 32'h0000_000f);
    chk("adc2_code", g2, 32'h0000_000b);
    chk("adc1_db", db1, 32'h0000_0018);
    chk("adc2_db", db2, 32'h0000_0014);
    @(posedge hclk);
    // trim with the fixed 10 pairs kept by the writer
    wr(8'h78, 32'h0000_bf81);
    rd("trim", 8'h78, 32'h0000_bf81);
    @(negedge hclk);
    chk("vref2", vr2, 32'h0000_003f);
    chk("vref1", vr1, 32'h0000_0001);
    @(posedge hclk);
    // dsp modes from the bus, with the unused byte written high
    wr(8'h7c, 32'h0000_ff89);
    rd("mode", 8'h7c, 32'h0000_0089);
    @(negedge hclk);
    chk("conn_a", ca, 32'h0000_0002);
    chk("conn_b", cb, 32'h0000_0004);
    chk("opm", opm, 32'h0000_0001);
    @(posedge hclk);
    // dsp modes and trim from the dsp port
    u_dsp.put(8'h7c, 16'h0066);
    @(negedge hclk);
    chk("conn_a", ca, 32'h0000_0001);
    chk("conn_b", cb, 32'h0000_0003);
    chk("opm", opm, 32'h0000_0002);
    chk("dsp_rdata", dsp_rdata, 32'h0000_0066);
    @(posedge hclk);
    u_dsp.put(8'h78, 16'ha0a5);
    @(negedge hclk);
    chk("vref1", vr1, 32'h0000_0025);
    chk("dsp_rdata", dsp_rdata, 32'h0000_a0a5);
    @(posedge hclk);
    // pins as outputs, then pin0 back to input reading the pad
    wr(8'h7d, 32'h0000_0001);
    rd("pin0", 8'h7d, 32'h0000_0001);
    wr(8'h7e, 32'h0000_0000);
    rd("pin1", 8'h7e, 32'h0000_0000);
    @(negedge hclk);
    chk("pin0_oe", pe0, 32'h0000_0001);
    chk("pin0_o", po0, 32'h0000_0001);
    chk("pin1_oe", pe1, 32'h0000_0001);
    chk("pin1_o", po1, 32'h0000_0000);
    @(posedge hclk);
    pad_ext <= 2'b11;
    wr(8'h7d, 32'h0000_0002);
    rd("pin0_pad", 8'h7d, 32'h0000_0003);
    // reset in mid-run, then the dsp takes pin1 at the second edge after release
    do_reset(2);
    reset_look();
    u_dsp.put(8'h7e, 16'h0001);
    @(negedge hclk);
    chk("pin1_oe", pe1, 32'h0000_0001);
    chk("pin1_o", po1, 32'h0000_0001);
    @(posedge hclk);
    rd("pin1_dsp", 8'h7e, 32'h0000_0001);
    rd("trim_rst", 8'h78, 32'h0000_a0a0);
    complete_run();
  end

  // watchdog: the tests need about 85 cycles, a hang ends as a failure
  initial begin
    repeat (3000) @(posedge hclk);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
